// [rtl/pad_cfg.svh]
// Purpose: constants of the peripheral auto powerdown block
// Assumes: byte addresses on a 32-bit wishbone bus
// Notes:   floppy register offsets are the 3-bit port offsets
`ifndef PAD_CFG_SVH
`define PAD_CFG_SVH
`define PAD_CLK_MHZ          125
`define PAD_FDC_PD_TIME_MS   10
`define PAD_OFS_AUTO_PWR     8'h00
`define PAD_OFS_PAR_CFG      8'h04
`define PAD_OFS_PD_STATUS    8'h08
`define PAD_AUTO_PWR_RESET   8'h00
`define PAD_PAR_CFG_RESET    8'h00
`define PAD_BIT_FDC_AUTO     0
`define PAD_BIT_PAR_AUTO     3
`define PAD_BIT_UART_AUTO_A  4
`define PAD_BIT_UART_AUTO_B  5
`define PAD_BIT_EPP_EN       0
`define PAD_BIT_ECP_EN       1
`define PAD_ECR_LSB          2
`define PAD_FDC_STATUS_A     3'h0
`define PAD_FDC_STATUS_B     3'h1
`define PAD_FDC_DIG_OUT      3'h2
`define PAD_FDC_MAIN_STAT    3'h4
`define PAD_FDC_DATA         3'h5
`define PAD_FDC_DIG_IN       3'h7
`define PAD_DOC_RESET        8'h04
`define PAD_DOC_NRESET_BIT   2
`define PAD_RSC_RESET_BIT    7
`define PAD_MSR_IDLE         8'h80
`endif

// [rtl/pad_pkg.sv]
// Purpose: types of the peripheral auto powerdown block
// Assumes: nothing beyond the cfg header
// Notes:   outputs toward the drive travel as one struct
package pad_pkg;
    typedef enum logic [2:0] {
        PAD_ECR_SPP   = 3'h0,
        PAD_ECR_BIDIR = 3'h1,
        PAD_ECR_FIFO  = 3'h2,
        PAD_ECR_ECP   = 3'h3,
        PAD_ECR_EPP   = 3'h4,
        PAD_ECR_RSV   = 3'h5,
        PAD_ECR_TEST  = 3'h6,
        PAD_ECR_CFG   = 3'h7
    } pad_ecr_t;
    typedef enum logic {
        PAD_FDC_AWAKE = 1'b0,
        PAD_FDC_ASLEEP = 1'b1
    } pad_fdc_state_t;
    typedef struct packed {
        logic       motor_on_0;
        logic       drive_select_0;
        logic       write_pulse_out;
        logic       write_gate_out;
        logic       step_direction_out;
        logic       step_pulse_out;
        logic       head_select_out;
        logic [1:0] drive_density_out;
    } pad_drive_t;
    typedef struct packed {
        logic read_pulse_in;
        logic write_protect_in;
        logic track_zero_in;
        logic index_pulse_in;
        logic disk_change_in;
    } pad_sense_t;
endpackage : pad_pkg

// [rtl/pad_top.sv]
// Purpose: auto powerdown control of floppy, serial and parallel units
// Assumes: floppy register accesses arrive as one-cycle strobes from the host bus decode
// Notes:   all control bits but the shadowed floppy registers live behind a classic wishbone slave
`timescale 1ns/10ps
`default_nettype none
`include "pad_cfg.svh"
module pad_top
    import pad_pkg::*;
#(
    parameter int unsigned NUM_UART      = 2,
    parameter int unsigned FDC_PD_CYCLES = `PAD_FDC_PD_TIME_MS * 1000 * `PAD_CLK_MHZ
)(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                fdc_acc_i,
    input  wire logic                fdc_we_i,
    input  wire logic [2:0]          fdc_adr_i,
    input  wire logic [7:0]          fdc_wdat_i,
    output logic      [7:0]          fdc_rdat_o,
    input  wire logic [7:0]          fdc_status_a_i,
    input  wire logic [7:0]          fdc_status_b_i,
    input  wire logic [7:0]          fdc_main_status_i,
    input  wire logic [7:0]          fdc_data_i,
    input  wire logic [7:0]          fdc_dig_in_i,
    input  wire logic                fdc_int_i,
    input  wire logic                fdc_unload_done_i,
    output logic      [7:0]          fdc_dig_out_o,
    output logic      [7:0]          fdc_rate_o,
    output logic      [7:0]          fdc_xfer_rate_o,
    output logic                     fdc_wake_o,
    output logic                     fdc_run_o,
    output logic                     fdc_asleep_o,
    input  wire pad_drive_t          drive_core_i,
    output pad_drive_t               drive_o,
    output pad_drive_t               drive_oe_o,
    input  wire pad_sense_t          sense_i,
    output pad_sense_t               sense_o,
    input  wire logic [NUM_UART-1:0] uart_tx_write_i,
    input  wire logic [NUM_UART-1:0] uart_thr_empty_i,
    input  wire logic [NUM_UART-1:0] uart_tsr_empty_i,
    input  wire logic [NUM_UART-1:0] uart_rx_fifo_empty_i,
    input  wire logic [NUM_UART-1:0] uart_rx_idle_i,
    input  wire logic [NUM_UART-1:0] serial_receive_input_i,
    input  wire logic [NUM_UART-1:0] ring_indicator_i,
    output logic      [NUM_UART-1:0] uart_tx_asleep_o,
    output logic      [NUM_UART-1:0] uart_rx_asleep_o,
    output logic      [NUM_UART-1:0] ring_change_o,
    output logic                     epp_asleep_o,
    output logic                     ecp_asleep_o
);
    localparam int unsigned TW = $clog2(FDC_PD_CYCLES + 1);

    // floppy register access decode
    function automatic logic fdc_waking(input logic we, input logic [2:0] adr, input logic [7:0] d);
        logic w;
        w = 1'b0;
        if (adr == `PAD_FDC_DATA)
            w = 1'b1;
        else if (adr == `PAD_FDC_MAIN_STAT)
            w = !we || d[`PAD_RSC_RESET_BIT];
        else if (adr == `PAD_FDC_DIG_OUT)
            w = we && ((d[7:4] != 4'h0) || !d[`PAD_DOC_NRESET_BIT]);
        return w;
    endfunction : fdc_waking

    logic [7:0]     auto_power_control_q;
    logic [7:0]     par_cfg_q;
    logic [7:0]     dig_out_q;
    logic [7:0]     rate_q;
    logic [7:0]     xfer_rate_q;
    pad_fdc_state_t fdc_state_q;
    pad_fdc_state_t fdc_state_d;
    logic [TW-1:0]  fdc_timer_q;
    logic [TW-1:0]  fdc_timer_d;
    logic           ack_q;
    logic [31:0]    rdat_q;
    logic [NUM_UART-1:0] tx_pd_q;
    logic [NUM_UART-1:0] rx_pd_q;
    logic [NUM_UART-1:0] rxd_prev_q;
    logic [NUM_UART-1:0] ri_prev_q;
    logic [NUM_UART-1:0] ri_chg_q;
    logic           epp_pd_q;
    logic           ecp_pd_q;

    wire logic        wb_req      = wb_cyc_i && wb_stb_i && !ack_q;
    wire logic        wb_wr       = wb_req && wb_we_i && wb_sel_i[0];
    wire logic        sel_auto    = (wb_adr_i == `PAD_OFS_AUTO_PWR);
    wire logic        sel_par     = (wb_adr_i == `PAD_OFS_PAR_CFG);
    wire logic        sel_stat    = (wb_adr_i == `PAD_OFS_PD_STATUS);
    wire logic        fdc_en      = auto_power_control_q[`PAD_BIT_FDC_AUTO];
    wire logic        uart_en     = auto_power_control_q[`PAD_BIT_UART_AUTO_A]
                                    && auto_power_control_q[`PAD_BIT_UART_AUTO_B];
    wire logic        par_en      = auto_power_control_q[`PAD_BIT_PAR_AUTO];
    wire logic        epp_cfg     = par_cfg_q[`PAD_BIT_EPP_EN];
    wire logic        ecp_cfg     = par_cfg_q[`PAD_BIT_ECP_EN];
    wire pad_ecr_t    ecr_mode    = pad_ecr_t'(par_cfg_q[`PAD_ECR_LSB +: 3]);
    wire logic        fdc_wake    = fdc_acc_i && fdc_waking(fdc_we_i, fdc_adr_i, fdc_wdat_i);
    wire logic        fdc_wr      = fdc_acc_i && fdc_we_i;
    wire logic        fdc_idle    = (dig_out_q[7:4] == 4'h0) && (fdc_main_status_i == `PAD_MSR_IDLE)
                                    && !fdc_int_i && fdc_unload_done_i;
    wire logic        fdc_timeout = (fdc_timer_q == TW'(FDC_PD_CYCLES));
    wire logic        fdc_asleep  = (fdc_state_q == PAD_FDC_ASLEEP);
    wire logic        ecr_epp     = (ecr_mode == PAD_ECR_EPP);
    wire logic        ecr_compat  = (ecr_mode == PAD_ECR_SPP) || (ecr_mode == PAD_ECR_BIDIR) || ecr_epp;
    wire logic        epp_pd_d    = par_en && (!epp_cfg || (ecp_cfg && !ecr_epp));
    wire logic        ecp_pd_d    = par_en && (!ecp_cfg || ecr_compat);
    wire logic [31:0] status_word = {21'h0, ecp_pd_q, epp_pd_q, |rx_pd_q, |tx_pd_q, 6'h0, fdc_asleep};
    wire logic [31:0] rdat_d      = sel_auto ? {24'h0, auto_power_control_q} :
                                    sel_par  ? {24'h0, par_cfg_q} :
                                    sel_stat ? status_word : 32'h0;

    // wishbone slave, one wait state; unmapped reads give zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0;
        end
        else if (ce_i)
        begin
            ack_q  <= wb_req;
            rdat_q <= rdat_d;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            auto_power_control_q <= `PAD_AUTO_PWR_RESET;
            par_cfg_q            <= `PAD_PAR_CFG_RESET;
        end
        else if (ce_i && wb_wr)
        begin
            if (sel_auto)
                auto_power_control_q <= wb_dat_i[7:0];
            if (sel_par)
                par_cfg_q <= wb_dat_i[7:0];
        end
    end

    // shadowed floppy control registers; stored even while asleep
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dig_out_q   <= `PAD_DOC_RESET;
            rate_q      <= 8'h0;
            xfer_rate_q <= 8'h0;
        end
        else if (ce_i && fdc_wr)
        begin
            if (fdc_adr_i == `PAD_FDC_DIG_OUT)
                dig_out_q <= fdc_wdat_i;
            if (fdc_adr_i == `PAD_FDC_MAIN_STAT)
                rate_q <= fdc_wdat_i;
            if (fdc_adr_i == `PAD_FDC_DIG_IN)
                xfer_rate_q <= fdc_wdat_i;
        end
    end

    // floppy powerdown state and timer
    always_comb
    begin
        fdc_state_d = fdc_state_q;
        fdc_timer_d = fdc_timer_q;
        unique case (fdc_state_q)
            PAD_FDC_AWAKE:
            begin
                if (!fdc_en || fdc_wake)
                    fdc_timer_d = '0;
                else if (!fdc_timeout)
                    fdc_timer_d = fdc_timer_q + TW'(1);
                else if (fdc_idle)
                    fdc_state_d = PAD_FDC_ASLEEP;
            end
            PAD_FDC_ASLEEP:
            begin
                if (!fdc_en || fdc_wake)
                begin
                    fdc_state_d = PAD_FDC_AWAKE;
                    fdc_timer_d = '0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fdc_state_q <= PAD_FDC_AWAKE;
            fdc_timer_q <= '0;
        end
        else if (ce_i)
        begin
            fdc_state_q <= fdc_state_d;
            fdc_timer_q <= fdc_timer_d;
        end
    end

    // live read path: status never depends on the sleep state
    always_comb
    begin
        unique case (fdc_adr_i)
            `PAD_FDC_STATUS_A:  fdc_rdat_o = fdc_status_a_i;
            `PAD_FDC_STATUS_B:  fdc_rdat_o = fdc_status_b_i;
            `PAD_FDC_DIG_OUT:   fdc_rdat_o = dig_out_q;
            `PAD_FDC_MAIN_STAT: fdc_rdat_o = fdc_main_status_i;
            `PAD_FDC_DATA:      fdc_rdat_o = fdc_data_i;
            `PAD_FDC_DIG_IN:    fdc_rdat_o = fdc_dig_in_i;
            default:            fdc_rdat_o = 8'h0;
        endcase
    end

    // core clocks only for the cycle of a non-waking access, then drops back
    assign fdc_run_o       = !fdc_asleep || fdc_acc_i;
    assign fdc_wake_o      = fdc_asleep && fdc_wake;
    assign fdc_asleep_o    = fdc_asleep;
    assign fdc_dig_out_o   = dig_out_q;
    assign fdc_rate_o      = rate_q;
    assign fdc_xfer_rate_o = xfer_rate_q;
    // bus pins are not gated by the powerdown state at all
    assign wb_ack_o        = ack_q;
    assign wb_dat_o        = rdat_q;

    // drive pins: write path and selection float asleep, head positioning stays driven
    assign drive_o    = drive_core_i;
    assign drive_oe_o = '{motor_on_0:         !fdc_asleep,
                          drive_select_0:     !fdc_asleep,
                          write_pulse_out:    !fdc_asleep,
                          write_gate_out:     !fdc_asleep,
                          step_direction_out: 1'b1,
                          step_pulse_out:     1'b1,
                          head_select_out:    1'b1,
                          drive_density_out:  2'b11};
    assign sense_o    = sense_i;

    // serial ports
    generate
        for (genvar u = 0; u < NUM_UART; u++)
        begin : g_uart
            wire logic rxd_edge = serial_receive_input_i[u] != rxd_prev_q[u];
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    tx_pd_q[u]    <= 1'b0;
                    rx_pd_q[u]    <= 1'b0;
                    rxd_prev_q[u] <= 1'b1;
                    ri_prev_q[u]  <= 1'b0;
                    ri_chg_q[u]   <= 1'b0;
                end
                else if (ce_i)
                begin
                    // a write wins over the empty condition in the same cycle
                    tx_pd_q[u]    <= uart_en && !uart_tx_write_i[u]
                                     && uart_thr_empty_i[u] && uart_tsr_empty_i[u];
                    rx_pd_q[u]    <= uart_en && !rxd_edge
                                     && uart_rx_fifo_empty_i[u] && uart_rx_idle_i[u];
                    rxd_prev_q[u] <= serial_receive_input_i[u];
                    ri_prev_q[u]  <= ring_indicator_i[u];
                    ri_chg_q[u]   <= ring_indicator_i[u] != ri_prev_q[u];
                end
            end
        end
    endgenerate

    assign uart_tx_asleep_o = tx_pd_q;
    assign uart_rx_asleep_o = rx_pd_q;
    assign ring_change_o    = ri_chg_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            epp_pd_q <= 1'b0;
            ecp_pd_q <= 1'b0;
        end
        else if (ce_i)
        begin
            epp_pd_q <= epp_pd_d;
            ecp_pd_q <= ecp_pd_d;
        end
    end

    assign epp_asleep_o = epp_pd_q;
    assign ecp_asleep_o = ecp_pd_q;

    nowake_reads_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && fdc_asleep && fdc_en && fdc_acc_i && !fdc_we_i
        && (fdc_adr_i inside {`PAD_FDC_STATUS_A, `PAD_FDC_STATUS_B, `PAD_FDC_DIG_IN}) |=> fdc_asleep)
        else $error("status read woke the floppy unit");

    live_status_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fdc_adr_i == `PAD_FDC_STATUS_B |-> fdc_rdat_o == fdc_status_b_i)
        else $error("status b read is not live");

    run_drops_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fdc_asleep && !fdc_acc_i |-> !fdc_run_o)
        else $error("floppy core runs while asleep and idle");

    msr_wakes_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && fdc_acc_i && !fdc_we_i && fdc_adr_i == `PAD_FDC_MAIN_STAT |=> !fdc_asleep && fdc_timer_q == '0)
        else $error("main status read did not wake");

    dor_motor_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && fdc_asleep && fdc_wr && fdc_adr_i == `PAD_FDC_DIG_OUT
        && fdc_wdat_i[7:4] == 4'h0 && fdc_wdat_i[`PAD_DOC_NRESET_BIT] && fdc_en |=> fdc_asleep)
        else $error("plain output control write woke the unit");

    pins_float_a: assert property (@(posedge clk_i) disable iff (rst_i)
        fdc_asleep |-> !drive_oe_o.motor_on_0 && !drive_oe_o.write_gate_out && drive_oe_o.step_pulse_out)
        else $error("drive pin enables wrong while asleep");

    uart_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !auto_power_control_q[`PAD_BIT_UART_AUTO_B] && ce_i |=> tx_pd_q == '0 && rx_pd_q == '0)
        else $error("serial slept without both enable bits");

    tx_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && uart_tx_write_i[0] |=> !tx_pd_q[0])
        else $error("transmitter asleep after buffer write");

    sleep_late_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(fdc_asleep) |-> $past(fdc_timeout) && $past(fdc_en))
        else $error("floppy slept before its timer ran out");

    ecp_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && par_en && ecr_mode == PAD_ECR_EPP |=> ecp_pd_q)
        else $error("ecp logic awake in epp mode");
endmodule : pad_top
`default_nettype wire

// [verification/pad_fdc_model.sv]
// Purpose: floppy core stand-in that feeds live status into the block
// Assumes: the bench decides when the core is busy
// Notes:   values move every cycle, so a stale read shows at once
`timescale 1ns/10ps
`default_nettype none
`include "pad_cfg.svh"
module pad_fdc_model
    import pad_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       busy_i,
    output logic      [7:0] cnt_o,
    output logic      [7:0] main_status_o,
    output pad_drive_t      drive_o
);
    always_ff @(posedge clk_i)
    begin
        cnt_o <= rst_i ? 8'h00 : cnt_o + 8'h01;
    end
    // a busy core never shows the idle main status
    assign main_status_o = busy_i ? 8'h10 : `PAD_MSR_IDLE;
    assign drive_o       = {cnt_o, 1'h1};
endmodule : pad_fdc_model
`default_nettype wire

// [verification/pad_top_tb.sv]
// Purpose: self-checking bench of the auto powerdown block
// Assumes: powerdown timer shortened to PD cycles
// Notes:   unload done, clock enable and the serial status lines are driven by the scenarios
`timescale 1ns/10ps
`default_nettype none
`include "pad_cfg.svh"
module pad_top_tb
    import pad_pkg::*;
;
    localparam int unsigned PD = 20;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
    logic [7:0] adr = 8'h00, fwd = 8'h00, cnt, controller_main_status, rdat, dout, rate, xrate, exp_dout;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd_q;
    logic acc = 1'h0, fwe = 1'h0, busy = 1'h0, fint = 1'h0, wake, asleep, epp_s, ecp_s;
    logic unl = 1'h1, ce = 1'h1, run;
    logic [2:0] fadr = 3'h0;
    pad_drive_t core, drv, drv_oe;
    pad_sense_t sense = 5'h15, sense_q;
    // receive lines idle high, as the far side holds them between characters
    logic [1:0] txw = 2'h0, thr = 2'h3, tsr = 2'h3, rxf = 2'h3, rxi = 2'h3, srin = 2'h3, ring = 2'h0;
    logic [1:0] tx_s, rx_s, ring_chg;
    int errors = 0, comparisons = 0;

    pad_top #(.FDC_PD_CYCLES(PD)) pad_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rd_q), .wb_ack_o(ack),
        .fdc_acc_i(acc), .fdc_we_i(fwe), .fdc_adr_i(fadr), .fdc_wdat_i(fwd), .fdc_rdat_o(rdat),
        .fdc_status_a_i(cnt), .fdc_status_b_i(~cnt), .fdc_main_status_i(controller_main_status),
        .fdc_data_i(cnt ^ 8'h5a), .fdc_dig_in_i({cnt[3:0], cnt[7:4]}), .fdc_int_i(fint),
        .fdc_unload_done_i(unl), .fdc_dig_out_o(dout), .fdc_rate_o(rate), .fdc_xfer_rate_o(xrate),
        .fdc_wake_o(wake), .fdc_run_o(run), .fdc_asleep_o(asleep), .drive_core_i(core), .drive_o(drv),
        .drive_oe_o(drv_oe), .sense_i(sense), .sense_o(sense_q), .uart_tx_write_i(txw),
        .uart_thr_empty_i(thr), .uart_tsr_empty_i(tsr), .uart_rx_fifo_empty_i(rxf),
        .uart_rx_idle_i(rxi), .serial_receive_input_i(srin), .ring_indicator_i(ring),
        .uart_tx_asleep_o(tx_s), .uart_rx_asleep_o(rx_s), .ring_change_o(ring_chg),
        .epp_asleep_o(epp_s), .ecp_asleep_o(ecp_s));
    pad_fdc_model pad_fdc_model_inst (.clk_i(clk_i), .rst_i(rst_i), .busy_i(busy), .cnt_o(cnt),
        .main_status_o(controller_main_status), .drive_o(core));

    always #4 clk_i = ~clk_i;

    task automatic end_of_test;
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one classic cycle; the wait ends only on ack or the bench limit
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'h1 && n < 50);
        q = rd_q;
        cyc <= 1'h0;
        stb <= 1'h0;
        if (n >= 50)
            errors++;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, d, 4'hf, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, 4'hf, q);
        check("register read", q, exp);
    endtask : rd_chk

    function automatic logic [7:0] live(input logic [2:0] a);
        case (a)
            3'h0: return cnt;
            3'h1: return ~cnt;
            3'h2: return exp_dout;
            3'h4: return controller_main_status;
            3'h5: return cnt ^ 8'h5a;
            3'h7: return {cnt[3:0], cnt[7:4]};
            default: return 8'h00;
        endcase
    endfunction : live

    task automatic fdc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic ew);
        @(posedge clk_i);
        acc <= 1'h1;
        fwe <= w;
        fadr <= a;
        fwd <= d;
        @(negedge clk_i);
        check("fdc wake", wake, ew);
        check("fdc run", run, 1'h1);
        if (!w)
            check("fdc read", rdat, live(a));
        @(posedge clk_i);
        acc <= 1'h0;
    endtask : fdc

    task automatic wait_sleep(output int n);
        n = 0;
        while (asleep !== 1'h1 && n < 80)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask : wait_sleep

    task automatic t_reset;
        logic [31:0] q;
        check("output control reset", dout, `PAD_DOC_RESET);
        check("drive enables", drv_oe, 9'h1ff);
        check("asleep flags", {epp_s, ecp_s, tx_s, rx_s, asleep}, 32'h0);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        rd_chk(8'h08, 32'h0);
        rd_chk(8'h0c, 32'h0);
        wb(1'h1, 8'h00, 32'h39, 4'he, q);
        rd_chk(8'h00, 32'h0);
        wr(8'h08, 32'h1);
        rd_chk(8'h08, 32'h0);
    endtask : t_reset

    task automatic t_floppy;
        int n;
        // {write, offset, data, wakes}
        logic [19:0] tbl [13] = '{20'h00000, 20'h01000, 20'h07000, 20'h02000, 20'h17020, 20'h120c0,
            20'h14010, 20'h04001, 20'h05001, 20'h15001, 20'h12141, 20'h12001, 20'h14801};
        exp_dout = `PAD_DOC_RESET;
        wr(8'h00, 32'h1);
        for (int i = 0; i < 13; i++)
        begin
            wait_sleep(n);
            check("fdc asleep", asleep, 1'h1);
            if (i == 0)
            begin
                check("drive enables asleep", drv_oe, 9'h01f);
                check("drive outputs", drv, core);
                check("sense pass", sense_q, sense);
                rd_chk(8'h08, 32'h1);
            end
            fdc(tbl[i][16], tbl[i][14:12], tbl[i][11:4], tbl[i][0]);
            if (tbl[i][16] && tbl[i][14:12] == 3'h2)
                exp_dout = tbl[i][11:4];
            @(negedge clk_i);
            check("fdc state", asleep, !tbl[i][0]);
            check("core run", run, tbl[i][0]);
            if (i == 7)
                check("stored writes", {dout, rate, xrate}, 24'h0c0102);
            if (i == 10)
            begin
                repeat (40) @(posedge clk_i);
                #1;
                check("motor keeps awake", asleep, 1'h0);
            end
            if (tbl[i][0])
            begin
                fdc(1'h1, 3'h2, 8'h0c, 1'h0);
                exp_dout = 8'h0c;
                wait_sleep(n);
                // the motor-on wait already ran the timer out, so motors off sleeps at once
                check("rearm span", (i == 10) ? (n < 4) : (n >= PD - 5 && n < 60), 1'h1);
            end
        end
        @(posedge clk_i);
        busy <= 1'h1;
        fdc(1'h0, 3'h4, 8'h00, 1'h1);
        repeat (40) @(posedge clk_i);
        busy <= 1'h0;
        fint <= 1'h1;
        #1;
        check("busy keeps awake", asleep, 1'h0);
        repeat (40) @(posedge clk_i);
        fint <= 1'h0;
        unl <= 1'h0;
        #1;
        check("interrupt keeps awake", asleep, 1'h0);
        repeat (40) @(posedge clk_i);
        unl <= 1'h1;
        #1;
        check("unload keeps awake", asleep, 1'h0);
        wait_sleep(n);
        check("idle sleeps again", asleep, 1'h1);
        wr(8'h00, 32'h0);
        #1;
        check("disable wakes", asleep, 1'h0);
    endtask : t_floppy

    task automatic t_serial;
        logic got;
        wr(8'h00, 32'h10);
        repeat (3) @(posedge clk_i);
        #1;
        check("tx one bit", {tx_s, rx_s}, 4'h0);
        wr(8'h00, 32'h30);
        repeat (3) @(posedge clk_i);
        #1;
        check("serial asleep", {tx_s, rx_s}, 4'hf);
        rd_chk(8'h08, 32'h180);
        @(posedge clk_i);
        // one unmet condition per port and direction
        thr <= 2'h2;
        tsr <= 2'h1;
        rxf <= 2'h2;
        rxi <= 2'h1;
        repeat (2) @(posedge clk_i);
        #1;
        check("busy ports awake", {tx_s, rx_s}, 4'h0);
        @(posedge clk_i);
        thr <= 2'h3;
        tsr <= 2'h3;
        rxf <= 2'h3;
        rxi <= 2'h3;
        repeat (2) @(posedge clk_i);
        txw <= 2'h1;
        srin <= 2'h1;
        ring <= 2'h1;
        @(posedge clk_i);
        txw <= 2'h0;
        #1;
        check("wake on write and edge", {tx_s, rx_s}, 4'h9);
        got = 1'h0;
        repeat (4)
        begin
            @(negedge clk_i);
            got = got | (ring_chg === 2'h1);
        end
        check("ring change", got, 1'h1);
        check("tx back asleep", tx_s, 2'h3);
        // with the clock enable low a ring change must wait until it returns
        @(posedge clk_i);
        ce <= 1'h0;
        ring <= 2'h0;
        @(posedge clk_i);
        #1;
        check("frozen ring flag", ring_chg, 2'h0);
        @(posedge clk_i);
        ce <= 1'h1;
        @(posedge clk_i);
        #1;
        check("ring after thaw", ring_chg, 2'h1);
    endtask : t_serial

    task automatic t_parallel;
        logic [4:0] c;
        logic [2:0] m;
        for (int i = 0; i < 32; i++)
        begin
            c = i[4:0];
            m = (c[3:2] == 2'h2) ? 3'h3 : ((c[3:2] == 2'h3) ? 3'h4 : {2'h0, c[2]});
            wr(8'h00, {28'h0, c[4], 3'h0});
            wr(8'h04, {27'h0, m, c[1:0]});
            repeat (2) @(posedge clk_i);
            #1;
            check("epp asleep", epp_s, c[4] & (!c[0] | (c[1] & m != 3'h4)));
            check("ecp asleep", ecp_s, c[4] & (!c[1] | m == 3'h0 | m == 3'h1 | m == 3'h4));
        end
    endtask : t_parallel

    initial
    begin
        repeat (20000) @(posedge clk_i);
        errors++;
        end_of_test;
    end

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        t_reset;
        t_floppy;
        t_serial;
        t_parallel;
        end_of_test;
    end
endmodule : pad_top_tb
`default_nettype wire
